// ### logic/dwp_pkg.sv
package dwp_pkg;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_UNIT_STATE = 8'h0c;

   // Control register fields.
   localparam int CTRL_LOCK_EN_BIT = 0;
   localparam int CTRL_UNIT_LSB = 4;
   localparam int CTRL_CYL_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0771;

   // Event bits, shared by status and mask.
   localparam int EV_READ_ONLY = 0;
   localparam int EV_LOCKOUT = 1;
   localparam int EV_NOT_READY = 2;
   localparam int EV_W = 3;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

   // Unit state fields.
   localparam int ST_READY_LSB = 0;
   localparam int ST_RO_LSB = 8;
   localparam int ST_ONLINE_LSB = 16;

   // Geometry.
   localparam int UNITS = 8;
   localparam int UNIT_W = 3;
   localparam int CYL_W = 8;

   // Spin-up time after start.
   localparam int CLK_HZ = 10_000_000;
   localparam int SPINUP_S = 60;
   localparam int SPINUP_CYCLES = SPINUP_S * CLK_HZ;
   localparam int SPIN_W = 30;

   typedef enum logic [1:0] {FN_NONE, FN_READ, FN_WRITE} dwp_fn_t;
endpackage

// ### logic/dwp_write_protect.sv
`timescale 1ns/1ps
// Contract
// - Read/write switch setting allows reads and writes on the selected unit.
// - Read-only switch protects whole unit; writes refused with interrupt.
// - Lockout disabled means no cylinder restriction on any unit.
// - Lockout applies only to the unit equal to the unit selector.
// - Protected range is cylinder zero through limit, inclusive.
// - Write to protected cylinder on lockout unit refused with interrupt.
// - Unit reports ready only after spin-up time from start.
// - Lockout unit selector is a three bit value.
// - Lockout cylinder limit is a three bit value.
module dwp_write_protect #(
   parameter int SPINUP = dwp_pkg::SPINUP_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive switches
   input wire logic [7:0] drv_read_only,
   input wire logic [7:0] drv_online,
   input wire logic [7:0] drv_start,
   // Function requests
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [2:0] req_unit,
   input wire logic [7:0] req_cyl,
   output logic req_done,
   output logic req_granted,
   output logic req_refused,
   // Drive gating and status
   output logic [7:0] write_gate,
   output logic [7:0] unit_ready,
   output logic irq
);

   function automatic logic bit_of(input logic [7:0] v,
                                   input logic [2:0] i);
      bit_of = v[i];
   endfunction

   logic [31:0] ctrl;
   logic [dwp_pkg::EV_W-1:0] irq_status;
   logic [dwp_pkg::EV_W-1:0] irq_mask;
   logic [dwp_pkg::SPIN_W-1:0] spin_cnt [dwp_pkg::UNITS];

   wire lockout_en = ctrl[dwp_pkg::CTRL_LOCK_EN_BIT];
   wire [2:0] lockout_unit_sel = ctrl[dwp_pkg::CTRL_UNIT_LSB +: 3];
   wire [2:0] lockout_cyl_limit = ctrl[dwp_pkg::CTRL_CYL_LSB +: 3];

   // Bus decode. The access phase always takes two cycles.
   wire acc = psel && penable && pready;
   wire hit_ctrl = paddr == dwp_pkg::ADDR_CTRL;
   wire hit_stat = paddr == dwp_pkg::ADDR_IRQ_STATUS;
   wire hit_mask = paddr == dwp_pkg::ADDR_IRQ_MASK;
   wire hit_unit = paddr == dwp_pkg::ADDR_UNIT_STATE;
   wire hit_any = hit_ctrl || hit_stat || hit_mask || hit_unit;
   wire wr_ctrl = acc && pwrite && hit_ctrl;
   wire wr_stat = acc && pwrite && hit_stat;
   wire wr_mask = acc && pwrite && hit_mask;

   wire [31:0] unit_state = {8'h00, drv_online, drv_read_only, unit_ready};
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl :
      hit_stat ? {29'h0, irq_status} :
      hit_mask ? {29'h0, irq_mask} :
      hit_unit ? unit_state : 32'h0000_0000;

   // Protection decision, looked at on every request.
   wire sel_ro = bit_of(drv_read_only, req_unit);
   wire sel_up = bit_of(drv_online, req_unit) &&
                 bit_of(unit_ready, req_unit);
   wire lock_hit = lockout_en &&
                   (req_unit == lockout_unit_sel) &&
                   (req_cyl <= {5'h00, lockout_cyl_limit});
   wire blk_ro = req_valid && req_write && sel_ro;
   wire blk_lock = req_valid && req_write && lock_hit;
   wire blk_down = req_valid && !sel_up;
   wire refuse = blk_ro || blk_lock || blk_down;

   wire [dwp_pkg::EV_W-1:0] events = {blk_down, blk_lock, blk_ro};
   wire [dwp_pkg::EV_W-1:0] clr = wr_stat ? pwdata[dwp_pkg::EV_W-1:0] :
                                  3'h0;
   // A new event wins over a clear in the same cycle.
   wire [dwp_pkg::EV_W-1:0] next_status = (irq_status & ~clr) | events;

   // Erase and record circuitry only on units that may write at all.
   wire [7:0] next_gate = ~drv_read_only & drv_online & unit_ready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !hit_any;
         prdata <= (psel && penable && !pready && !pwrite) ? rd_mux :
                   32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= dwp_pkg::CTRL_RESET;
         irq_mask <= dwp_pkg::MASK_RESET;
         irq_status <= 3'h0;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= pwdata & dwp_pkg::CTRL_MASK;
         end
         if (wr_mask) begin
            irq_mask <= pwdata[dwp_pkg::EV_W-1:0];
         end
         irq_status <= next_status;
         irq <= |(next_status & (wr_mask ? pwdata[dwp_pkg::EV_W-1:0] :
                                 irq_mask));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_done <= 1'b0;
         req_granted <= 1'b0;
         req_refused <= 1'b0;
         write_gate <= 8'h00;
      end else begin
         req_done <= req_valid;
         req_granted <= req_valid && !refuse;
         req_refused <= refuse;
         write_gate <= next_gate;
      end
   end

   // Each unit counts spin-up from its start switch; stopping restarts it.
   // Counters saturate so that ready stays up while the unit runs.
   // One process drives all units so the ready vector has a single driver.
   localparam logic [31:0] SPIN_LAST = SPINUP - 1;
   wire [dwp_pkg::SPIN_W-1:0] spin_lim = SPIN_LAST[dwp_pkg::SPIN_W-1:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int u = 0; u < dwp_pkg::UNITS; u++) begin
            spin_cnt[u] <= '0;
         end
         unit_ready <= 8'h00;
      end else begin
         for (int u = 0; u < dwp_pkg::UNITS; u++) begin
            if (!drv_start[u]) begin
               spin_cnt[u] <= '0;
               unit_ready[u] <= 1'b0;
            end else if (spin_cnt[u] < spin_lim) begin
               spin_cnt[u] <= spin_cnt[u] + 1'b1;
               unit_ready[u] <= 1'b0;
            end else begin
               unit_ready[u] <= 1'b1;
            end
         end
      end
   end

   // Independent count of started cycles on unit 0, used only by a check.
   logic [dwp_pkg::SPIN_W-1:0] spin_seen;
   wire spin_due = 32'(spin_seen) >= SPINUP;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spin_seen <= '0;
      end else if (!drv_start[0]) begin
         spin_seen <= '0;
      end else if (!spin_due) begin
         spin_seen <= spin_seen + 1'b1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ro_write;
      req_valid && req_write && sel_ro;
   endsequence

   sequence s_refused_pulse;
      req_done && req_refused && !req_granted;
   endsequence

   property p_ro_refuse;
      s_ro_write |=> s_refused_pulse ##0 irq_status[dwp_pkg::EV_READ_ONLY];
   endproperty
   a_ro_refuse: assert property (p_ro_refuse)
      else $error("write to read-only unit was not refused");

   property p_rw_grant;
      req_valid && !req_write && sel_up |=> req_granted && !req_refused;
   endproperty
   a_rw_grant: assert property (p_rw_grant)
      else $error("read on ready unit was not granted");

   property p_gate_off;
      (write_gate & $past(drv_read_only)) == 8'h00;
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("write gate on for read-only unit");

   property p_no_lock;
      req_valid && req_write && !lockout_en && !sel_ro && sel_up
      |=> req_granted;
   endproperty
   a_no_lock: assert property (p_no_lock)
      else $error("write refused while lockout disabled");

   property p_other_unit;
      req_valid && req_write && req_unit != lockout_unit_sel &&
      !sel_ro && sel_up |=> req_granted;
   endproperty
   a_other_unit: assert property (p_other_unit)
      else $error("lockout hit a unit it does not select");

   property p_lock_range;
      req_valid && req_write && lockout_en &&
      req_unit == lockout_unit_sel && req_cyl <= 8'(lockout_cyl_limit)
      |=> req_refused ##0 irq_status[dwp_pkg::EV_LOCKOUT];
   endproperty
   a_lock_range: assert property (p_lock_range)
      else $error("protected cylinder write not refused");

   property p_lock_above;
      req_valid && req_write && !sel_ro && sel_up &&
      req_cyl > 8'(lockout_cyl_limit) |=> req_granted;
   endproperty
   a_lock_above: assert property (p_lock_above)
      else $error("cylinder above limit was refused");

   property p_ready_late;
      $rose(drv_start[0]) |-> !unit_ready[0] [*2];
   endproperty
   a_ready_late: assert property (p_ready_late)
      else $error("unit ready before spin-up");

   property p_offline;
      req_valid && !drv_online[req_unit] |=> req_refused ##0 !req_granted;
   endproperty
   a_offline: assert property (p_offline)
      else $error("off-line unit accepted a transfer");

   property p_both;
      req_valid && req_write && (sel_ro || lock_hit) |=> !req_granted;
   endproperty
   a_both: assert property (p_both)
      else $error("blocked write was granted");

   property p_irq;
      (irq_status & irq_mask) != 3'h0 && !wr_stat && !wr_mask |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt missing for unmasked event");

   property p_ready_due;
      unit_ready[0] == spin_due;
   endproperty
   a_ready_due: assert property (p_ready_due)
      else $error("unit ready does not match spin-up time");

   property p_ready_drop;
      !drv_start[0] |=> !unit_ready[0];
   endproperty
   a_ready_drop: assert property (p_ready_drop)
      else $error("unit ready stayed up after stop");

   property p_irq_level;
      irq == |(irq_status & irq_mask);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level does not follow unmasked status");

   property p_sticky;
      !wr_stat |=> (irq_status & $past(irq_status)) == $past(irq_status);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("status bit lost without a clear");

   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse)
      else $error("ready held longer than one cycle");

   property p_ready_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait)
      else $error("access phase not answered after one wait state");

   property p_slverr;
      pslverr |-> pready;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("slave error without ready");

   property p_done_pair;
      (req_granted || req_refused) == req_done &&
      !(req_granted && req_refused);
   endproperty
   a_done_pair: assert property (p_done_pair)
      else $error("request answer not exactly one of grant or refuse");

endmodule

// ### test/dwp_drive_model.sv
`timescale 1ns/1ps
module dwp_drive_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Operator settings
   input wire logic [7:0] want_ro,
   input wire logic [7:0] want_on,
   input wire logic [7:0] want_st,
   // Drive switch lines
   output logic [7:0] drv_read_only,
   output logic [7:0] drv_online,
   output logic [7:0] drv_start
);
   // Switches move only on an edge, so a setting never changes mid-cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_read_only <= 8'h00;
         drv_online <= 8'h00;
         drv_start <= 8'h00;
      end else begin
         drv_read_only <= want_ro;
         drv_online <= want_on;
         drv_start <= want_st;
      end
   end
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, req_valid = 0, req_write = 0;
   logic [2:0] req_unit = 3'h0;
   logic [7:0] req_cyl = 8'h00, ro = 8'h00, on = 8'h00, st = 8'h00;
   logic req_done, req_granted, req_refused, irq;
   logic [7:0] drv_read_only, drv_online, drv_start, write_gate, unit_ready;
   int fails = 0, cmp_count = 0;
   always #50 pclk = ~pclk;
   dwp_drive_model drv (.pclk(pclk), .presetn(presetn), .want_ro(ro),
      .want_on(on), .want_st(st), .drv_read_only(drv_read_only),
      .drv_online(drv_online), .drv_start(drv_start));
   dwp_write_protect #(.SPINUP(20)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drv_read_only(drv_read_only), .drv_online(drv_online),
      .drv_start(drv_start), .req_valid(req_valid), .req_write(req_write),
      .req_unit(req_unit), .req_cyl(req_cyl), .req_done(req_done),
      .req_granted(req_granted), .req_refused(req_refused),
      .write_gate(write_gate), .unit_ready(unit_ready), .irq(irq));
   task automatic results();
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (n == 20) begin
         fails++;
         results();
      end
   endtask
   task automatic rq(input logic w, input logic [2:0] u, input logic [7:0] c,
                     input logic r);
      @(posedge pclk);
      req_valid <= 1;
      req_write <= w;
      req_unit <= u;
      req_cyl <= c;
      @(posedge pclk);
      req_valid <= 0;
      #1;
      `CHK("done", 1'b1, req_done)
      `CHK("granted", ~r, req_granted)
      `CHK("refused", r, req_refused)
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      apb(0, dwp_pkg::ADDR_CTRL, 0);
      `CHK("ctrl", 32'h0, rd)
      apb(0, dwp_pkg::ADDR_IRQ_MASK, 0);
      `CHK("mask", 32'h0, rd)
      @(posedge pclk);
      st <= 8'hff;
      on <= 8'h7f;
      ro <= 8'h04;
      repeat (10) @(posedge pclk);
      `CHK("not ready", 8'h00, unit_ready)
      rq(0, 1, 0, 1);
      repeat (30) @(posedge pclk);
      `CHK("ready", 8'hff, unit_ready)
      `CHK("gate", 8'h7b, write_gate)
      apb(0, dwp_pkg::ADDR_UNIT_STATE, 0);
      `CHK("state", 32'h007f04ff, rd)
      apb(1, dwp_pkg::ADDR_CTRL, 32'h0000_0631);
      apb(0, dwp_pkg::ADDR_CTRL, 0);
      `CHK("ctrl rb", 32'h0000_0631, rd)
      rq(0, 2, 0, 0);
      rq(1, 2, 9, 1);
      rq(1, 1, 0, 0);
      rq(1, 3, 6, 1);
      rq(1, 3, 0, 1);
      rq(1, 3, 7, 0);
      rq(1, 4, 0, 0);
      rq(0, 3, 0, 0);
      rq(1, 7, 9, 1);
      `CHK("irq off", 1'b0, irq)
      apb(0, dwp_pkg::ADDR_IRQ_STATUS, 0);
      `CHK("status", 32'h7, rd)
      apb(1, dwp_pkg::ADDR_IRQ_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK("irq on", 1'b1, irq)
      apb(1, dwp_pkg::ADDR_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK("irq clr", 1'b0, irq)
      apb(0, dwp_pkg::ADDR_IRQ_STATUS, 0);
      `CHK("status clr", 32'h5, rd)
      apb(1, dwp_pkg::ADDR_CTRL, 32'h0000_0630);
      rq(1, 3, 0, 0);
      apb(0, 8'h10, 0);
      `CHK("unmapped", 1'b1, er)
      results();
   end
endmodule
